// ==== core/aio_consts.svh ====
`ifndef AIO_CONSTS_SVH
`define AIO_CONSTS_SVH
// Register byte offsets
`define AIO_OFS_TO_CFG    8'h00
`define AIO_OFS_IN_FUNC   8'h04
`define AIO_OFS_SCALE     8'h08
`define AIO_OFS_SWEEP     8'h0c
`define AIO_OFS_LIM_FREQ  8'h10
`define AIO_OFS_LIM_CURR  8'h14
`define AIO_OFS_LIM_FB    8'h18
`define AIO_OFS_STATUS    8'h1c
`define AIO_OFS_IRQ_STAT  8'h20
`define AIO_OFS_IRQ_MASK  8'h24
`define AIO_OFS_RESULT    8'h28
// Reset values
`define AIO_RST_TO_CFG    32'h0000000a
`define AIO_RST_IN_FUNC   32'h00000721
`define AIO_RST_SCALE     32'h00c82800
`define AIO_RST_ZERO      32'h00000000
// Setting limits, analogue levels in 0.1 units
`define AIO_TO_SEC_MIN    7'h01
`define AIO_TO_SEC_MAX    7'h63
`define AIO_ACT_MAX       3'h5
`define AIO_V_SUP_MIN     8'h0a
`define AIO_I_SUP_MIN     8'h14
`define AIO_AO_SEL_MAX    4'hc
`define AIO_REL_SEL_MAX   5'h1a
`define AIO_REL_SEL_GAP   5'h15
`define AIO_AO_BASE_4MA   8'h28
`define AIO_AO_SPAN_0     16'h00c8
`define AIO_AO_SPAN_4     16'h00a0
`define AIO_PERMILLE      16'h03e8
`define AIO_TEMP_LO       16'h0014
`define AIO_TEMP_HI       16'h0064
`define AIO_DIV_STEPS     6'h20
// Timing
`define AIO_CLK_PERIOD_NS 10
`define AIO_SECOND_NS     1000000000
`endif

// ==== core/aio_pkg.sv ====
package aio_pkg;
  typedef enum logic [1:0] {
    AIO_DIV_IDLE = 2'b00,
    AIO_DIV_RUN = 2'b01,
    AIO_DIV_DONE = 2'b10
  } aio_div_state_t;
  typedef enum logic [1:0] {
    AIO_JOB_CUR_IN = 2'b00,
    AIO_JOB_AOUT = 2'b01,
    AIO_JOB_SWEEP = 2'b10
  } aio_job_t;
  typedef enum logic [3:0] {
    AIO_FN_NONE = 4'h0,
    AIO_FN_REF = 4'h1,
    AIO_FN_FB = 4'h2,
    AIO_FN_SWEEP = 4'ha
  } aio_in_fn_t;
endpackage

// ==== core/aio_top.sv ====
// Notes on behaviour
// - Current input at min scaling gives minimum
// - Current input at max scaling gives maximum
// - Time-out period 1 to 99 s, default 10
// - Below half minimum too long fires action
// - Supervise only above 1 V or 2 mA
// - Action codes 0 to 5, default none
// - Analogue time-out beats bus time-out
// - Sweep on current input: full scale equals delta frequency
// - Output source codes 0-12, odd 0-20 mA
// - Output proportional across the selected interval
// - Temperature 20 to 100 C spans output
// - Relay limit and window comparison codes
// - Relay closed while condition true
// - Relay follows control word bit 11
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`include "aio_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module aio_top #(
  parameter int SEC_CYCLES = `AIO_SECOND_NS / `AIO_CLK_PERIOD_NS
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [7:0] VOLT_IN,
  input wire logic [7:0] CURR_IN,
  input wire logic [15:0] REF_VAL,
  input wire logic [15:0] REF_MIN,
  input wire logic [15:0] REF_MAX,
  input wire logic [15:0] FEEDBACK_VAL,
  input wire logic [15:0] FEEDBACK_FLOOR,
  input wire logic [15:0] FEEDBACK_CEILING,
  input wire logic [15:0] OUT_FREQ,
  input wire logic [15:0] FREQ_MAX,
  input wire logic [15:0] OUT_CURR,
  input wire logic [15:0] RATED_INVERTER_CURRENT,
  input wire logic [15:0] OUT_POWER,
  input wire logic [15:0] MOTOR_POWER,
  input wire logic [7:0] HEATSINK_TEMP,
  input wire logic [31:0] STATE_FLAGS,
  input wire logic [15:0] CTRL_WORD,
  input wire logic BUS_TIMEOUT,
  input wire logic [2:0] BUS_ACTION,
  output logic [15:0] CUR_IN_SCALED,
  output logic [15:0] SWEEP_DELTA_OUT,
  output logic [7:0] AO_LEVEL,
  output logic RELAY_ON,
  output logic [2:0] TIMEOUT_ACTION,
  output logic IRQ
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) m[8*b +: 8] = nw[8*b +: 8];
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] to_cfg_ff, in_func_ff, scale_ff, sweep_ff;
  logic [31:0] lim_freq_ff, lim_curr_ff, lim_fb_ff;
  logic [2:0] irq_stat_ff, irq_mask_ff;
  logic [31:0] rd_data, wr_val;
  logic wb_hit, wb_wr;
  logic [1:0] lost_vec;
  logic relay_ff;
  logic [2:0] action_ff;
  logic [15:0] cur_scaled_ff;
  logic [7:0] ao_ff;

  assign wb_hit = WB_CYC_I && WB_STB_I && !ack_ff;
  assign wb_wr = wb_hit && WB_WE_I;

  always_comb begin
    wr_val = 32'h00000000;
    rd_data = 32'h00000000;
    case (WB_ADR_I)
      `AIO_OFS_TO_CFG: rd_data = to_cfg_ff;
      `AIO_OFS_IN_FUNC: rd_data = in_func_ff;
      `AIO_OFS_SCALE: rd_data = scale_ff;
      `AIO_OFS_SWEEP: rd_data = sweep_ff;
      `AIO_OFS_LIM_FREQ: rd_data = lim_freq_ff;
      `AIO_OFS_LIM_CURR: rd_data = lim_curr_ff;
      `AIO_OFS_LIM_FB: rd_data = lim_fb_ff;
      `AIO_OFS_STATUS: rd_data = {25'h0000000, action_ff, 1'b0, relay_ff, lost_vec};
      `AIO_OFS_IRQ_STAT: rd_data = {29'h00000000, irq_stat_ff};
      `AIO_OFS_IRQ_MASK: rd_data = {29'h00000000, irq_mask_ff};
      `AIO_OFS_RESULT: rd_data = {8'h00, ao_ff, cur_scaled_ff};
      default: rd_data = 32'h00000000;
    endcase
    wr_val = merge(rd_data, WB_DAT_I, WB_SEL_I);
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= wb_hit;
      dat_ff <= (wb_hit && !WB_WE_I) ? rd_data : 32'h00000000;
    end
  end

  // Invalid codes leave the whole register unchanged rather than half-applied
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      to_cfg_ff <= `AIO_RST_TO_CFG;
      in_func_ff <= `AIO_RST_IN_FUNC;
      scale_ff <= `AIO_RST_SCALE;
      sweep_ff <= `AIO_RST_ZERO;
      lim_freq_ff <= `AIO_RST_ZERO;
      lim_curr_ff <= `AIO_RST_ZERO;
      lim_fb_ff <= `AIO_RST_ZERO;
      irq_mask_ff <= 3'h0;
    end else if (wb_wr) begin
      case (WB_ADR_I)
        `AIO_OFS_TO_CFG:
          if (wr_val[6:0] >= `AIO_TO_SEC_MIN && wr_val[6:0] <= `AIO_TO_SEC_MAX &&
              wr_val[10:8] <= `AIO_ACT_MAX) begin
            to_cfg_ff <= {21'h000000, wr_val[10:8], 1'b0, wr_val[6:0]};
          end
        `AIO_OFS_IN_FUNC:
          if (wr_val[3:0] inside {4'h0, 4'h1, 4'h2, 4'ha} &&
              wr_val[7:4] inside {4'h0, 4'h1, 4'h2, 4'ha} &&
              wr_val[11:8] <= `AIO_AO_SEL_MAX && wr_val[20:16] <= `AIO_REL_SEL_MAX &&
              wr_val[20:16] != `AIO_REL_SEL_GAP) begin
            in_func_ff <= {11'h000, wr_val[20:16], 4'h0, wr_val[11:0]};
          end
        `AIO_OFS_SCALE: scale_ff <= {8'h00, wr_val[23:0]};
        `AIO_OFS_SWEEP: sweep_ff <= {16'h0000, wr_val[15:0]};
        `AIO_OFS_LIM_FREQ: lim_freq_ff <= wr_val;
        `AIO_OFS_LIM_CURR: lim_curr_ff <= wr_val;
        `AIO_OFS_LIM_FB: lim_fb_ff <= wr_val;
        `AIO_OFS_IRQ_MASK: irq_mask_ff <= wr_val[2:0];
        default: ;
      endcase
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;

  wire [6:0] to_sec = to_cfg_ff[6:0];
  wire [2:0] to_action = to_cfg_ff[10:8];
  wire [3:0] volt_fn = in_func_ff[3:0];
  wire [3:0] cur_fn = in_func_ff[7:4];
  wire [3:0] ao_sel = in_func_ff[11:8];
  wire [4:0] relay_sel = in_func_ff[20:16];
  wire [7:0] volt_min = scale_ff[7:0];
  wire [7:0] cur_min = scale_ff[15:8];
  wire [7:0] cur_max = scale_ff[23:16];

  ////////////////////////////////////////////////////////////////////////////
  // Loss-of-signal supervision, one timer per analogue input

  logic [7:0] sig_lvl [2];
  logic [7:0] sig_min [2];
  logic [7:0] sup_thr [2];
  logic [3:0] sig_fn [2];
  logic [1:0] below_vec, sup_vec;

  assign sig_lvl[0] = VOLT_IN;
  assign sig_lvl[1] = CURR_IN;
  assign sig_min[0] = volt_min;
  assign sig_min[1] = cur_min;
  assign sup_thr[0] = `AIO_V_SUP_MIN;
  assign sup_thr[1] = `AIO_I_SUP_MIN;
  assign sig_fn[0] = volt_fn;
  assign sig_fn[1] = cur_fn;

  for (genvar i = 0; i < 2; i++) begin : g_to
    logic [26:0] cyc_ff;
    logic [6:0] sec_ff;
    logic lost_ff;
    // Only reference or feedback inputs with a usable floor are watched
    assign sup_vec[i] = (sig_fn[i] == aio_pkg::AIO_FN_REF || sig_fn[i] == aio_pkg::AIO_FN_FB)
                        && sig_min[i] > sup_thr[i];
    assign below_vec[i] = {1'b0, sig_lvl[i], 1'b0} < {2'b00, sig_min[i]};
    assign lost_vec[i] = lost_ff;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
        cyc_ff <= 27'h0000000;
        sec_ff <= 7'h00;
        lost_ff <= 1'b0;
      end else if (!sup_vec[i] || !below_vec[i]) begin
        cyc_ff <= 27'h0000000;
        sec_ff <= 7'h00;
        lost_ff <= 1'b0;
      end else if (sec_ff >= to_sec) begin
        lost_ff <= 1'b1;
      end else if (cyc_ff == 27'(SEC_CYCLES - 1)) begin
        cyc_ff <= 27'h0000000;
        sec_ff <= sec_ff + 7'h01;
      end else begin
        cyc_ff <= cyc_ff + 27'h0000001;
      end
    end
  end

  // Analogue loss outranks the bus watchdog even when both hit together
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) action_ff <= 3'h0;
    else if (|lost_vec) action_ff <= to_action;
    else if (BUS_TIMEOUT) action_ff <= BUS_ACTION;
    else action_ff <= 3'h0;
  end
  assign TIMEOUT_ACTION = action_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Shared scaling divider: (x - lo) * span / (hi - lo), one job at a time

  aio_pkg::aio_div_state_t div_st_ff;
  aio_pkg::aio_job_t job_ff;
  logic [31:0] quo_ff;
  logic [16:0] rem_ff;
  logic [15:0] den_ff, base_ff;
  logic [5:0] step_ff;
  logic [15:0] j_x, j_lo, j_hi, j_span;
  logic [7:0] j_base;
  logic [16:0] rem_sh;
  logic [15:0] sweep_ff_o;

  always_comb begin
    j_x = {8'h00, CURR_IN};
    j_lo = {8'h00, cur_min};
    j_hi = {8'h00, cur_max};
    j_span = `AIO_PERMILLE;
    j_base = 8'h00;
    if (job_ff == aio_pkg::AIO_JOB_SWEEP) begin
      j_span = sweep_ff[15:0];
    end else if (job_ff == aio_pkg::AIO_JOB_AOUT) begin
      j_base = ao_sel[0] ? 8'h00 : `AIO_AO_BASE_4MA;
      j_span = ao_sel[0] ? `AIO_AO_SPAN_0 : `AIO_AO_SPAN_4;
      case (ao_sel)
        4'h1, 4'h2: begin j_x = REF_VAL; j_lo = REF_MIN; j_hi = REF_MAX; end
        4'h3, 4'h4: begin j_x = FEEDBACK_VAL; j_lo = FEEDBACK_FLOOR; j_hi = FEEDBACK_CEILING; end
        4'h5, 4'h6: begin j_x = OUT_FREQ; j_lo = 16'h0000; j_hi = FREQ_MAX; end
        4'h7, 4'h8: begin j_x = OUT_CURR; j_lo = 16'h0000; j_hi = RATED_INVERTER_CURRENT; end
        4'h9, 4'ha: begin j_x = OUT_POWER; j_lo = 16'h0000; j_hi = MOTOR_POWER; end
        4'hb, 4'hc: begin
          j_x = {8'h00, HEATSINK_TEMP};
          j_lo = `AIO_TEMP_LO;
          j_hi = `AIO_TEMP_HI;
        end
        default: begin j_x = 16'h0000; j_lo = 16'h0000; j_hi = 16'h0000; j_span = 16'h0000; end
      endcase
    end
  end

  assign rem_sh = {rem_ff[15:0], quo_ff[31]};

  // Division is spread over 32 cycles: an input change may take up to 140 cycles to show
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_st_ff <= aio_pkg::AIO_DIV_IDLE;
      job_ff <= aio_pkg::AIO_JOB_CUR_IN;
      quo_ff <= 32'h00000000;
      rem_ff <= 17'h00000;
      den_ff <= 16'h0000;
      base_ff <= 16'h0000;
      step_ff <= 6'h00;
    end else begin
      case (div_st_ff)
        aio_pkg::AIO_DIV_IDLE: begin
          base_ff <= {8'h00, j_base};
          rem_ff <= 17'h00000;
          den_ff <= j_hi - j_lo;
          step_ff <= 6'h00;
          if (j_x <= j_lo) begin
            quo_ff <= 32'h00000000;
            div_st_ff <= aio_pkg::AIO_DIV_DONE;
          end else if (j_x >= j_hi) begin
            quo_ff <= {16'h0000, j_span};
            div_st_ff <= aio_pkg::AIO_DIV_DONE;
          end else begin
            quo_ff <= {16'h0000, j_x - j_lo} * {16'h0000, j_span};
            div_st_ff <= aio_pkg::AIO_DIV_RUN;
          end
        end
        aio_pkg::AIO_DIV_RUN: begin
          if (rem_sh >= {1'b0, den_ff}) begin
            rem_ff <= rem_sh - {1'b0, den_ff};
            quo_ff <= {quo_ff[30:0], 1'b1};
          end else begin
            rem_ff <= rem_sh;
            quo_ff <= {quo_ff[30:0], 1'b0};
          end
          step_ff <= step_ff + 6'h01;
          if (step_ff == `AIO_DIV_STEPS - 6'h01) div_st_ff <= aio_pkg::AIO_DIV_DONE;
        end
        aio_pkg::AIO_DIV_DONE: begin
          div_st_ff <= aio_pkg::AIO_DIV_IDLE;
          job_ff <= (job_ff == aio_pkg::AIO_JOB_SWEEP) ? aio_pkg::AIO_JOB_CUR_IN :
                    aio_pkg::aio_job_t'(job_ff + 2'h1);
        end
        default: div_st_ff <= aio_pkg::AIO_DIV_IDLE;
      endcase
    end
  end

  wire div_done = div_st_ff == aio_pkg::AIO_DIV_DONE;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur_scaled_ff <= 16'h0000;
      ao_ff <= 8'h00;
      sweep_ff_o <= 16'h0000;
    end else if (div_done) begin
      if (job_ff == aio_pkg::AIO_JOB_CUR_IN) cur_scaled_ff <= quo_ff[15:0];
      if (job_ff == aio_pkg::AIO_JOB_AOUT) begin
        ao_ff <= (ao_sel == 4'h0) ? 8'h00 : 8'(base_ff + quo_ff[15:0]);
      end
      if (job_ff == aio_pkg::AIO_JOB_SWEEP) begin
        sweep_ff_o <= (cur_fn == aio_pkg::AIO_FN_SWEEP) ? quo_ff[15:0] : 16'h0000;
      end
    end
  end
  assign CUR_IN_SCALED = cur_scaled_ff;
  assign AO_LEVEL = ao_ff;
  assign SWEEP_DELTA_OUT = sweep_ff_o;

  ////////////////////////////////////////////////////////////////////////////
  // Relay condition

  logic relay_cond;
  wire [15:0] f_lo = lim_freq_ff[15:0];
  wire [15:0] f_hi = lim_freq_ff[31:16];
  wire [15:0] i_lo = lim_curr_ff[15:0];
  wire [15:0] i_hi = lim_curr_ff[31:16];
  wire [15:0] feedback_low_warning_level = lim_fb_ff[15:0];
  wire [15:0] feedback_high_warning_level = lim_fb_ff[31:16];

  always_comb begin
    case (relay_sel)
      5'h00: relay_cond = 1'b0;
      5'h0b: relay_cond = OUT_FREQ > f_lo;
      5'h0c: relay_cond = OUT_FREQ < f_hi;
      5'h0d: relay_cond = OUT_CURR > i_lo;
      5'h0e: relay_cond = OUT_CURR < i_hi;
      5'h0f: relay_cond = FEEDBACK_VAL > feedback_low_warning_level;
      5'h10: relay_cond = FEEDBACK_VAL < feedback_high_warning_level;
      5'h16: relay_cond = OUT_FREQ < f_lo || OUT_FREQ > f_hi;
      5'h17: relay_cond = OUT_CURR < i_lo || OUT_CURR > i_hi;
      5'h18: relay_cond = FEEDBACK_VAL < feedback_low_warning_level ||
                          FEEDBACK_VAL > feedback_high_warning_level;
      5'h1a: relay_cond = CTRL_WORD[11];
      default: relay_cond = STATE_FLAGS[relay_sel];
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) relay_ff <= 1'b0;
    else relay_ff <= relay_cond;
  end
  assign RELAY_ON = relay_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: a new event wins over a same-cycle write-one-to-clear

  logic [1:0] lost_d_ff;
  logic relay_d_ff, irq_ff;
  logic [2:0] ev;
  assign ev = {relay_ff ^ relay_d_ff, lost_vec & ~lost_d_ff};

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lost_d_ff <= 2'h0;
      relay_d_ff <= 1'b0;
      irq_stat_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      lost_d_ff <= lost_vec;
      relay_d_ff <= relay_ff;
      irq_stat_ff <= (irq_stat_ff & ~((wb_wr && WB_ADR_I == `AIO_OFS_IRQ_STAT) ?
                     wr_val[2:0] : 3'h0)) | ev;
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end
  assign IRQ = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_low_watched;
    sup_vec[1] && below_vec[1];
  endsequence
  sequence s_recover;
    !below_vec[1];
  endsequence

  AST_TO_RANGE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    to_sec >= `AIO_TO_SEC_MIN && to_sec <= `AIO_TO_SEC_MAX)
    else $error("Time-out period out of range");
  AST_LOST_CAUSE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(lost_vec[1]) |-> $past(sup_vec[1] && below_vec[1]) && $past(g_to[1].sec_ff) == to_sec)
    else $error("Loss flagged without elapsed period");
  AST_NO_SUP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !sup_vec[0] |=> !lost_vec[0])
    else $error("Loss flagged on unsupervised input");
  AST_ACT_CODE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    |lost_vec |=> TIMEOUT_ACTION == $past(to_action) && TIMEOUT_ACTION <= `AIO_ACT_MAX)
    else $error("Wrong time-out action");
  AST_PRIORITY: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (|lost_vec && BUS_TIMEOUT) |=> TIMEOUT_ACTION == $past(to_action))
    else $error("Bus action overrode analogue action");
  AST_RESTART: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_low_watched ##1 s_recover |=> g_to[1].sec_ff == 7'h00 && g_to[1].cyc_ff == 27'h0000000)
    else $error("Time-out not restarted");
  AST_AO_FLOOR: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (div_done && job_ff == aio_pkg::AIO_JOB_AOUT && ao_sel != 4'h0 && !ao_sel[0])
    |=> AO_LEVEL >= `AIO_AO_BASE_4MA)
    else $error("4-20 mA output below 4 mA");
  AST_CUR_MIN: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (div_st_ff == aio_pkg::AIO_DIV_IDLE && job_ff == aio_pkg::AIO_JOB_CUR_IN && j_x <= j_lo)
    ##2 1'b1 |=> CUR_IN_SCALED == 16'h0000)
    else $error("Minimum current not mapped to minimum");
  AST_CUR_MAX: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (div_st_ff == aio_pkg::AIO_DIV_IDLE && job_ff == aio_pkg::AIO_JOB_CUR_IN && j_x >= j_hi &&
     j_x > j_lo) ##2 1'b1 |=> CUR_IN_SCALED == `AIO_PERMILLE)
    else $error("Maximum current not mapped to maximum");
  AST_NO_GAP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    relay_sel != `AIO_REL_SEL_GAP && relay_sel <= `AIO_REL_SEL_MAX)
    else $error("Unoffered relay code selected");
  AST_RELAY: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $stable(in_func_ff) && relay_cond |=> RELAY_ON)
    else $error("Relay not closed on true condition");
  AST_CW11: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    relay_sel == 5'h1a && $stable(relay_sel) |-> RELAY_ON == $past(CTRL_WORD[11]))
    else $error("Relay not following control word bit");

endmodule
`default_nettype wire

// ==== sim/aio_plant.sv ====
`timescale 1ns/1ps
`default_nettype none
module aio_plant (
  output logic [15:0] ref_val,
  output logic [15:0] ref_min,
  output logic [15:0] ref_max,
  output logic [15:0] fb_val,
  output logic [15:0] fb_floor,
  output logic [15:0] fb_ceiling,
  output logic [15:0] out_freq,
  output logic [15:0] freq_max,
  output logic [15:0] out_curr,
  output logic [15:0] rated_curr,
  output logic [15:0] out_power,
  output logic [15:0] motor_power
);
  // Each process value sits at mid-interval, so every output source reads half scale
  // Non-zero lower bounds catch a source scaled from zero instead of its floor
  assign ref_val = 16'h01f4;
  assign ref_min = 16'h0000;
  assign ref_max = 16'h03e8;
  assign fb_val = 16'h00c8;
  assign fb_floor = 16'h0064;
  assign fb_ceiling = 16'h012c;
  assign out_freq = 16'h00fa;
  assign freq_max = 16'h01f4;
  assign out_curr = 16'h0032;
  assign rated_curr = 16'h0064;
  assign out_power = 16'h001e;
  assign motor_power = 16'h003c;
endmodule
`default_nettype wire

// ==== sim/aio_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module analog_io_timeout_and_output_select_tb_top;
  logic SYS_CLK;
  logic RST_N = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, bus_to = 1'b0;
  logic [7:0] adr = 8'h00, volt = 8'h00, curr = 8'h78, temp = 8'h3c;
  logic [31:0] wdat = 32'h0, flags = 32'h0, cmp = 32'h00c1c800;
  logic [15:0] ctrl = 16'h0000;
  logic [2:0] bus_act = 3'h0;
  logic [7:0] cin [4] = '{8'h28, 8'hc8, 8'h78, 8'h14};
  logic [15:0] cexp [4] = '{16'h0000, 16'h03e8, 16'h01f4, 16'h0000};
  wire logic [15:0] rv, rmn, rmx, fv, ffl, fce, ofq, fmx, ocr, ric, opw, mpw, cur_sc, swp;
  wire logic [31:0] dat_o;
  wire logic [7:0] ao;
  wire logic [2:0] act;
  wire logic ack, relay, irq;
  int err_total = 0;
  int check_count = 0;
  //////////////////////////////////////////////////
  aio_plant plant (.ref_val(rv), .ref_min(rmn), .ref_max(rmx), .fb_val(fv), .fb_floor(ffl),
    .fb_ceiling(fce), .out_freq(ofq), .freq_max(fmx), .out_curr(ocr), .rated_curr(ric),
    .out_power(opw), .motor_power(mpw));
  // A second is shortened to 20 cycles so a time-out fits in a few dozen cycles
  aio_top #(.SEC_CYCLES(20)) dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .VOLT_IN(volt), .CURR_IN(curr), .REF_VAL(rv),
    .REF_MIN(rmn), .REF_MAX(rmx), .FEEDBACK_VAL(fv), .FEEDBACK_FLOOR(ffl),
    .FEEDBACK_CEILING(fce), .OUT_FREQ(ofq), .FREQ_MAX(fmx), .OUT_CURR(ocr),
    .RATED_INVERTER_CURRENT(ric), .OUT_POWER(opw), .MOTOR_POWER(mpw), .HEATSINK_TEMP(temp),
    .STATE_FLAGS(flags), .CTRL_WORD(ctrl), .BUS_TIMEOUT(bus_to), .BUS_ACTION(bus_act),
    .CUR_IN_SCALED(cur_sc), .SWEEP_DELTA_OUT(swp), .AO_LEVEL(ao), .RELAY_ON(relay),
    .TIMEOUT_ACTION(act), .IRQ(irq));
  //////////////////////////////////////////////////
  task test_done();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  // Waits on ack with a bound; read data is taken at the very edge that sees ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge SYS_CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = dat_o;
    if (n == 50) begin
      chk1(1'b0, 1'b1);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  function automatic logic flag_code(input int c);
    return (c >= 1 && c <= 10) || (c >= 17 && c <= 20) || c == 25;
  endfunction
  //////////////////////////////////////////////////
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    #200000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    rd(8'h00, 32'h0000000a);
    rd(8'h04, 32'h00000721);
    rd(8'h08, 32'h00c82800);
    wr(8'h00, 32'h00000000);
    wr(8'h00, 32'h00000064);
    wr(8'h00, 32'h0000060a);
    rd(8'h00, 32'h0000000a);
    wr(8'h00, 32'h00000563);
    rd(8'h00, 32'h00000563);
    wr(8'h04, 32'h00150721);
    wr(8'h04, 32'h00000d21);
    rd(8'h04, 32'h00000721);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h00000000);
    // Three divider jobs run in turn, so a new input may need up to 140 cycles to show
    for (int i = 0; i < 4; i++) begin
      curr <= cin[i];
      tick(150);
      chk({16'h0, cur_sc}, {16'h0, cexp[i]});
    end
    rd(8'h28, 32'h00640000);
    wr(8'h0c, 32'h00000032);
    wr(8'h04, 32'h000007a1);
    curr <= 8'h78;
    tick(150);
    chk({16'h0, swp}, 32'h00000019);
    curr <= 8'hc8;
    tick(150);
    chk({16'h0, swp}, 32'h00000032);
    for (int c = 0; c < 13; c++) begin
      wr(8'h04, {20'h00000, 4'(c), 8'h21});
      tick(150);
      chk({24'h0, ao}, (c == 0) ? 32'h0 : (c % 2 == 1) ? 32'h64 : 32'h78);
    end
    temp <= 8'h0a;
    tick(150);
    chk({24'h0, ao}, 32'h00000028);
    wr(8'h04, 32'h00000b21);
    tick(150);
    chk({24'h0, ao}, 32'h00000000);
    temp <= 8'h64;
    tick(150);
    chk({24'h0, ao}, 32'h000000c8);
    wr(8'h10, 32'h00c80064);
    wr(8'h14, 32'h0050003c);
    wr(8'h18, 32'h012c0064);
    for (int c = 0; c < 27; c++) begin
      if (c != 21) begin
        wr(8'h04, {11'h000, 5'(c), 16'h0721});
        flags <= 32'h1 << c;
        ctrl <= 16'h0800;
        tick(4);
        chk1(relay, flag_code(c) || c == 26 || cmp[c]);
        flags <= ~(32'h1 << c);
        ctrl <= 16'hf7ff;
        tick(4);
        chk1(relay, cmp[c]);
      end
    end
    wr(8'h04, 32'h00000721);
    // Level 1.9 mA doubles to 3.8, just under the 4.0 mA minimum
    for (int a = 1; a < 6; a++) begin
      wr(8'h00, {21'h0, 3'(a), 8'h01});
      curr <= 8'h13;
      tick(18);
      chk({29'h0, act}, 32'h0);
      tick(12);
      chk({29'h0, act}, 32'(a));
      chk1(irq, 1'b0);
      curr <= 8'h78;
      tick(5);
    end
    wr(8'h20, 32'h00000007);
    wr(8'h24, 32'h00000002);
    curr <= 8'h13;
    tick(15);
    curr <= 8'h78;
    tick(2);
    curr <= 8'h13;
    tick(15);
    chk({29'h0, act}, 32'h0);
    tick(15);
    chk({29'h0, act}, 32'h5);
    chk1(irq, 1'b1);
    rd(8'h1c, 32'h00000052);
    bus_to <= 1'b1;
    bus_act <= 3'h3;
    tick(3);
    chk({29'h0, act}, 32'h5);
    rd(8'h20, 32'h00000002);
    wr(8'h20, 32'h00000002);
    tick(3);
    chk1(irq, 1'b0);
    bus_to <= 1'b0;
    curr <= 8'h78;
    wr(8'h08, 32'h00c81400);
    curr <= 8'h00;
    tick(40);
    chk({29'h0, act}, 32'h0);
    // Voltage floor of 1.1 V turns supervision on for the grounded voltage input
    wr(8'h08, 32'h00c8140b);
    tick(30);
    chk({29'h0, act}, 32'h5);
    test_done();
  end
endmodule
`default_nettype wire
